/* File: pkg/uart_host_pkg.sv */
// Shared constants for the quad UART host port and its channel registers
`default_nettype none
package uart_host_pkg;
    // ********************
    // Bus shape
    // ********************
    localparam int NUM_CHAN = 4;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int DIV_W = 16;
    // ********************
    // Register offsets within a channel
    // ********************
    localparam logic [2:0] REG_HOLD = 3'h0;
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_FCR = 3'h2;
    localparam logic [2:0] REG_LCR = 3'h3;
    localparam logic [2:0] REG_MCR = 3'h4;
    localparam logic [2:0] REG_LSR = 3'h5;
    localparam logic [2:0] REG_MSR = 3'h6;
    localparam logic [2:0] REG_SPR = 3'h7;
    // ********************
    // Field positions and keys
    // ********************
    localparam int LCR_DLAB_BIT = 7;
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    localparam int MCR_PRESCALE_BIT = 7;
    localparam int MCR_RESUME_BIT = 5;
    localparam int MCR_IRQ_EN_BIT = 3;
    localparam int FIFO_STATUS_SUMMARY_TX_LSB = 0;
    localparam int FIFO_STATUS_SUMMARY_RX_LSB = 4;
    // ********************
    // Reset values
    // ********************
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] XON_RST = 8'h00;
    // ********************
    // Datapath and timing figures
    // ********************
    localparam int FIFO_DEPTH = 64;
    localparam int SAMPLE_RATE = 16;
    localparam logic [1:0] PRESCALE_DIV4_TOP = 2'h3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_PULSE_NS = 40;
endpackage : uart_host_pkg
`default_nettype wire

/* File: rtl/uart_chan_regs.sv */
// One channel's register set, prescaler and 16x sample tick generator
`default_nettype none
module uart_chan_regs
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic strap_div4_i,
    input wire logic wr_i,
    input wire logic rd_done_i,
    input wire logic [uart_host_pkg::ADDR_W-1:0] addr_i,
    input wire logic [uart_host_pkg::DATA_W-1:0] wdata_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [7:0] isr_i,
    input wire logic [7:0] lsr_i,
    input wire logic [7:0] msr_i,
    output logic [7:0] rdata_o,
    output logic tx_push_o,
    output logic rx_pop_o,
    output logic div4_o,
    output logic resume_any_o,
    output logic irq_en_o,
    output logic tick16_o
);
    import uart_host_pkg::*;

    typedef struct packed {
        logic [7:0] lcr;
        logic [7:0] ier;
        logic [7:0] fcr;
        logic [7:0] modem_control_reg;
        logic [7:0] dll;
        logic [7:0] dlm;
        logic [7:0] spr;
        logic [7:0] efr;
        logic [7:0] xon1;
        logic [7:0] xon2;
        logic [1:0] pre_cnt;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic push;
        logic pop;
    } chan_t;

    chan_t s;
    chan_t next_s;
    logic dlab;
    logic enh;
    logic [DIV_W-1:0] divisor;

    assign dlab = s.lcr[LCR_DLAB_BIT];
    assign enh = (s.lcr == LCR_ENH_KEY);
    assign divisor = {s.dlm, s.dll};

    // ********************
    // Read mux
    // ********************
    always_comb
    begin
        rdata_o = REG_RST;
        if (addr_i == REG_HOLD)
            rdata_o = dlab ? s.dll : rx_data_i;
        else if (addr_i == REG_IER)
            rdata_o = dlab ? s.dlm : s.ier;
        else if (addr_i == REG_FCR)
            rdata_o = enh ? s.efr : isr_i;
        else if (addr_i == REG_LCR)
            rdata_o = s.lcr;
        else if (addr_i == REG_MCR)
            rdata_o = enh ? s.xon1 : s.modem_control_reg;
        else if (addr_i == REG_LSR)
            rdata_o = enh ? s.xon2 : lsr_i;
        else if (addr_i == REG_MSR)
            rdata_o = msr_i;
        else
            rdata_o = s.spr;
    end

    // ********************
    // Next state
    // ********************
    always_comb
    begin
        next_s = s;
        next_s.push = 1'b0;
        next_s.pop = 1'b0;
        next_s.tick = 1'b0;
        // Prescaler ahead of the divisor, then 16x tick
        if (!s.modem_control_reg[MCR_PRESCALE_BIT] || s.pre_cnt == PRESCALE_DIV4_TOP)
        begin
            next_s.pre_cnt = 2'h0;
            if (divisor != '0)
            begin
                if (s.div_cnt >= divisor - 16'h0001)
                begin
                    next_s.div_cnt = '0;
                    next_s.tick = 1'b1;
                end
                else
                    next_s.div_cnt = s.div_cnt + 16'h0001;
            end
        end
        else
            next_s.pre_cnt = s.pre_cnt + 2'h1;
        if (wr_i)
        begin
            if (addr_i == REG_HOLD && dlab)
                next_s.dll = wdata_i;
            else if (addr_i == REG_HOLD)
                next_s.push = 1'b1;
            else if (addr_i == REG_IER && dlab)
                next_s.dlm = wdata_i;
            else if (addr_i == REG_IER)
                next_s.ier = wdata_i;
            else if (addr_i == REG_FCR && enh)
                next_s.efr = wdata_i;
            else if (addr_i == REG_FCR)
                next_s.fcr = wdata_i;
            else if (addr_i == REG_LCR)
                next_s.lcr = wdata_i;
            else if (addr_i == REG_MCR && enh)
                next_s.xon1 = wdata_i;
            else if (addr_i == REG_MCR)
                next_s.modem_control_reg = wdata_i;
            else if (addr_i == REG_LSR && enh)
                next_s.xon2 = wdata_i;
            else if (addr_i == REG_SPR)
                next_s.spr = wdata_i;
        end
        if (rd_done_i && addr_i == REG_HOLD && !dlab)
            next_s.pop = 1'b1;
        if (clear_i)
        begin
            next_s = '0;
            next_s.modem_control_reg[MCR_PRESCALE_BIT] = strap_div4_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign tx_push_o = s.push;
    assign rx_pop_o = s.pop;
    assign div4_o = s.modem_control_reg[MCR_PRESCALE_BIT];
    assign resume_any_o = s.modem_control_reg[MCR_RESUME_BIT];
    assign irq_en_o = s.modem_control_reg[MCR_IRQ_EN_BIT];
    assign tick16_o = s.tick;
endmodule : uart_chan_regs
`default_nettype wire

/* File: rtl/uart_host_port.sv */
// Host bus front end of the quad UART: decode, channel select, broadcast
`default_nettype none
// How it works
// - 8-bit data, 3 address lines, selects, strobes
// - Bus access is sampled on mclk_i, the clock that feeds the divisor
// - Cycles framed only by select and strobes
// - Shared data bus, selected channel drives reads
// - 16-style: one low select picks channel
// - All four selects low: broadcast write
// - 68-style: address pair picks the channel
// - Address pair ignored in 16-style mode
// - Reset clears channel registers, MCR bit 7 takes the strap
// - 64-byte transmit and receive FIFO per channel
// - Sample clock is 16x bit rate
// - Strap chooses divide-by-1 or divide-by-4 prescale
// - Modem control bit 7 overrides the strap
// - Modem bit 5: any character resumes transmit
// - 16-style: interrupt style pin or modem bit 3
// - One summary read shows all FIFO ready flags
// - Each channel owns its full register set
// - Style pin high 16-style, low 68-style
// - 68-style reset pin is active low
// - Strap sampled only at reset, high divide-by-1
module uart_host_port
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic bus_style_select_i,
    input wire logic reset_pin_i,
    input wire logic prescale_pin_select_i,
    input wire logic irq_style_pin_i,
    input wire logic chan_a_select_n_i,
    input wire logic chan_b_select_n_i,
    input wire logic chan_c_select_n_i,
    input wire logic chan_d_select_n_i,
    input wire logic shared_select_n_i,
    input wire logic read_write_i,
    input wire logic chan_addr_hi_i,
    input wire logic chan_addr_lo_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic status_select_n_i,
    input wire logic [uart_host_pkg::ADDR_W-1:0] addr_i,
    input wire logic [uart_host_pkg::DATA_W-1:0] data_i,
    input wire logic [uart_host_pkg::NUM_CHAN-1:0] tx_space_ready_n_i,
    input wire logic [uart_host_pkg::NUM_CHAN-1:0] rx_data_ready_n_i,
    input wire logic [uart_host_pkg::NUM_CHAN-1:0] irq_req_i,
    input wire logic [uart_host_pkg::NUM_CHAN*8-1:0] rx_data_i,
    input wire logic [uart_host_pkg::NUM_CHAN*8-1:0] isr_i,
    input wire logic [uart_host_pkg::NUM_CHAN*8-1:0] lsr_i,
    input wire logic [uart_host_pkg::NUM_CHAN*8-1:0] msr_i,
    output logic [uart_host_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic chan_reset_o,
    output logic [uart_host_pkg::DATA_W-1:0] tx_data_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] tx_push_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] rx_pop_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] div4_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] resume_any_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] tick16_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] irq_o,
    output logic [uart_host_pkg::NUM_CHAN-1:0] irq_oe_o
);
    import uart_host_pkg::*;

    // ********************
    // State
    // ********************
    typedef struct packed {
        logic init;
        logic clear;
        logic wr_busy;
        logic [NUM_CHAN-1:0] wr_sel;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic [NUM_CHAN-1:0] wr_pulse;
        logic rd_busy;
        logic [NUM_CHAN-1:0] rd_sel;
        logic [ADDR_W-1:0] rd_addr;
        logic [NUM_CHAN-1:0] rd_done;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic [NUM_CHAN-1:0] irq;
        logic [NUM_CHAN-1:0] irq_oe;
    } port_t;

    port_t s;
    port_t next_s;

    logic [NUM_CHAN-1:0] sel;
    logic bcast;
    logic rd_act;
    logic wr_act;
    logic wr_now;
    logic rd_now;
    logic stat_now;
    logic pin_reset;
    logic [NUM_CHAN-1:0] cs_low;
    logic [ADDR_W-1:0] chan_addr;
    logic [NUM_CHAN-1:0] wr_strobe;
    logic [DATA_W-1:0] fifo_status_summary;
    logic [7:0] ch_rdata [NUM_CHAN];
    logic [NUM_CHAN-1:0] ch_irq_en;
    logic [DATA_W-1:0] rd_mux;

    // ********************
    // Channel select decode
    // ********************
    assign cs_low = ~{chan_d_select_n_i, chan_c_select_n_i,
                      chan_b_select_n_i, chan_a_select_n_i};

    always_comb
    begin
        sel = '0;
        bcast = 1'b0;
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (bus_style_select_i)
        begin
            // Address pair is not looked at here
            rd_act = ~read_strobe_n_i;
            wr_act = ~write_strobe_n_i;
            if (cs_low == 4'h1 || cs_low == 4'h2 ||
                cs_low == 4'h4 || cs_low == 4'h8)
                sel = cs_low;
            else if (cs_low == 4'hf)
            begin
                sel = cs_low;
                bcast = 1'b1;
            end
            else
                sel = '0;
        end
        else if (!shared_select_n_i)
        begin
            sel = 4'h1 << {chan_addr_hi_i, chan_addr_lo_i};
            rd_act = read_write_i;
            wr_act = ~read_write_i;
        end
    end

    // Access framed purely by host select and strobe levels
    assign wr_now = wr_act && (sel != '0);
    assign rd_now = rd_act && (sel != '0) && !bcast;
    assign stat_now = rd_act && !status_select_n_i;
    assign chan_addr = rd_now ? addr_i : s.rd_addr;

    // ********************
    // Reset pin, polarity by bus style
    // ********************
    // One sample suffices: a pulse over 40 ns always spans a 25 ns edge
    assign pin_reset = bus_style_select_i ? reset_pin_i : ~reset_pin_i;

    // ********************
    // FIFO ready summary
    // ********************
    assign fifo_status_summary[FIFO_STATUS_SUMMARY_TX_LSB +: NUM_CHAN] = tx_space_ready_n_i;
    assign fifo_status_summary[FIFO_STATUS_SUMMARY_RX_LSB +: NUM_CHAN] = rx_data_ready_n_i;

    // ********************
    // Read data from the one selected channel
    // ********************
    always_comb
    begin
        rd_mux = '0;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            if (sel[i])
                rd_mux = ch_rdata[i];
        end
    end

    // ********************
    // Next state
    // ********************
    always_comb
    begin
        next_s = s;
        next_s.init = 1'b0;
        next_s.clear = pin_reset;
        next_s.wr_pulse = '0;
        next_s.rd_done = '0;
        // Write commits at the trailing strobe edge
        if (wr_now)
        begin
            next_s.wr_sel = sel;
            next_s.wr_addr = addr_i;
            next_s.wr_data = data_i;
        end
        else if (s.wr_busy)
            next_s.wr_pulse = s.wr_sel;
        next_s.wr_busy = wr_now;
        // Read: drive while a single channel or the status summary is addressed
        next_s.doe = 1'b0;
        if (stat_now)
        begin
            next_s.dout = fifo_status_summary;
            next_s.doe = 1'b1;
        end
        else if (rd_now)
        begin
            next_s.rd_sel = sel;
            next_s.rd_addr = addr_i;
            next_s.dout = rd_mux;
            next_s.doe = 1'b1;
        end
        else if (s.rd_busy)
            next_s.rd_done = s.rd_sel;
        next_s.rd_busy = rd_now;
        // Broadcast and plain writes never drive the bus
        if (wr_now)
            next_s.doe = 1'b0;
        // Interrupt pin style per channel
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            next_s.irq[i] = irq_req_i[i];
            if (bus_style_select_i && !irq_style_pin_i)
                next_s.irq_oe[i] = ch_irq_en[i];
            else
                next_s.irq_oe[i] = 1'b1;
        end
        if (s.clear || s.init)
        begin
            next_s.wr_busy = 1'b0;
            next_s.rd_busy = 1'b0;
            next_s.wr_pulse = '0;
            next_s.rd_done = '0;
        end
    end

    // ********************
    // Registers
    // ********************
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.init <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ********************
    // Per-channel register sets
    // ********************
    assign wr_strobe = s.wr_pulse;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++)
        begin : g_chan
            uart_chan_regs u_regs
            (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .clear_i(s.clear | s.init),
                .strap_div4_i(~prescale_pin_select_i),
                .wr_i(wr_strobe[g]),
                .rd_done_i(s.rd_done[g]),
                .addr_i(wr_strobe[g] ? s.wr_addr : chan_addr),
                .wdata_i(s.wr_data),
                .rx_data_i(rx_data_i[g*8 +: 8]),
                .isr_i(isr_i[g*8 +: 8]),
                .lsr_i(lsr_i[g*8 +: 8]),
                .msr_i(msr_i[g*8 +: 8]),
                .rdata_o(ch_rdata[g]),
                .tx_push_o(tx_push_o[g]),
                .rx_pop_o(rx_pop_o[g]),
                .div4_o(div4_o[g]),
                .resume_any_o(resume_any_o[g]),
                .irq_en_o(ch_irq_en[g]),
                .tick16_o(tick16_o[g])
            );
        end
    endgenerate

    // ********************
    // Outputs
    // ********************
    assign data_o = s.dout;
    assign data_oe_o = s.doe;
    assign chan_reset_o = s.clear | s.init;
    assign tx_data_o = s.wr_data;
    assign irq_o = s.irq;
    assign irq_oe_o = s.irq_oe;
endmodule : uart_host_port
`default_nettype wire

/* File: verification/uart_host_port_chk.sv */
// Concurrent checks on the quad UART host port pins
`default_nettype none
module uart_host_port_chk
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic bus_style_select_i,
    input wire logic reset_pin_i,
    input wire logic prescale_pin_select_i,
    input wire logic irq_style_pin_i,
    input wire logic chan_a_select_n_i,
    input wire logic chan_b_select_n_i,
    input wire logic chan_c_select_n_i,
    input wire logic chan_d_select_n_i,
    input wire logic shared_select_n_i,
    input wire logic read_write_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic status_select_n_i,
    input wire logic [3:0] tx_space_ready_n_i,
    input wire logic [3:0] rx_data_ready_n_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic chan_reset_o,
    input wire logic [3:0] tx_push_o,
    input wire logic [3:0] div4_o,
    input wire logic [3:0] irq_oe_o
);
    logic [3:0] sel_n;
    logic any_sel;
    logic rd_any;
    logic wr_any;
    logic pin_act;
    // ********************
    // Decoded bus activity
    // ********************
    assign sel_n = {chan_d_select_n_i, chan_c_select_n_i,
        chan_b_select_n_i, chan_a_select_n_i};
    assign any_sel = bus_style_select_i ? sel_n != 4'hf : !shared_select_n_i;
    assign rd_any = bus_style_select_i ? !read_strobe_n_i
        : !shared_select_n_i && read_write_i;
    assign wr_any = bus_style_select_i ? !write_strobe_n_i && sel_n != 4'hf
        : !shared_select_n_i && !read_write_i;
    assign pin_act = bus_style_select_i ? reset_pin_i : !reset_pin_i;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_bcast_rd;
        (bus_style_select_i && sel_n == 4'h0 && !read_strobe_n_i) [*2];
    endsequence
    sequence s_stat_rd;
        (!status_select_n_i && rd_any) [*3];
    endsequence
    property p_bcast_quiet;
        s_bcast_rd |-> !data_oe_o;
    endproperty
    property p_oe_cause;
        data_oe_o |-> $past(rd_any) || $past(rd_any, 2);
    endproperty
    property p_push_shape;
        tx_push_o != 4'h0 |-> $onehot(tx_push_o) || tx_push_o == 4'hf;
    endproperty
    property p_push_cause;
        tx_push_o != 4'h0 |-> !$past(wr_any) && $past(wr_any, 4);
    endproperty
    property p_idle;
        (!any_sel) [*6] |-> tx_push_o == 4'h0;
    endproperty
    property p_status;
        s_stat_rd |-> data_oe_o
            && data_o == {rx_data_ready_n_i, tx_space_ready_n_i};
    endproperty
    property p_rel_clear;
        $fell(rst_i) |-> ##[0:2] chan_reset_o;
    endproperty
    property p_strap;
        $fell(rst_i) |-> ##[1:4] div4_o == {4{!prescale_pin_select_i}};
    endproperty
    property p_pin_reset;
        pin_act |-> ##[1:4] chan_reset_o;
    endproperty
    property p_irq_cont;
        (bus_style_select_i && irq_style_pin_i) [*3] |-> irq_oe_o == 4'hf;
    endproperty
    a_bcast_quiet: assert property (p_bcast_quiet)
        else $error("data bus driven on broadcast read");
    a_oe_cause: assert property (p_oe_cause)
        else $error("data bus driven without a read");
    a_push_shape: assert property (p_push_shape)
        else $error("write reached an odd channel mix");
    a_push_cause: assert property (p_push_cause)
        else $error("write effect not framed by strobe");
    a_idle: assert property (p_idle)
        else $error("write effect with nothing selected");
    a_status: assert property (p_status)
        else $error("fifo summary byte wrong");
    a_rel_clear: assert property (p_rel_clear)
        else $error("no channel clear after reset");
    a_strap: assert property (p_strap)
        else $error("prescaler does not follow strap");
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin ignored");
    a_irq_cont: assert property (p_irq_cont)
        else $error("continuous interrupt not driven");
endmodule : uart_host_port_chk
bind uart_host_port uart_host_port_chk i_chk (.mclk_i(mclk_i),
    .rst_i(rst_i), .bus_style_select_i(bus_style_select_i),
    .reset_pin_i(reset_pin_i), .prescale_pin_select_i(prescale_pin_select_i),
    .irq_style_pin_i(irq_style_pin_i), .chan_a_select_n_i(chan_a_select_n_i),
    .chan_b_select_n_i(chan_b_select_n_i),
    .chan_c_select_n_i(chan_c_select_n_i),
    .chan_d_select_n_i(chan_d_select_n_i),
    .shared_select_n_i(shared_select_n_i), .read_write_i(read_write_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .status_select_n_i(status_select_n_i),
    .tx_space_ready_n_i(tx_space_ready_n_i),
    .rx_data_ready_n_i(rx_data_ready_n_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .chan_reset_o(chan_reset_o),
    .tx_push_o(tx_push_o), .div4_o(div4_o), .irq_oe_o(irq_oe_o));
`default_nettype wire

/* File: verification/uart_host_model.sv */
// Host processor model driving the quad UART bus
`default_nettype none
module uart_host_model
(
    input wire logic mclk_i,
    input wire logic style16_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_i,
    input wire logic [3:0] push_i,
    input wire logic [3:0] pop_i,
    output logic [3:0] sel_n_o,
    output logic shared_select_n_o,
    output logic read_write_o,
    output logic [1:0] chan_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic status_select_n_o,
    output logic [2:0] addr_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sel_n_o = 4'hf;
        shared_select_n_o = 1'b1;
        read_write_o = 1'b1;
        chan_o = 2'h0;
        read_strobe_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        status_select_n_o = 1'b1;
        addr_o = 3'h0;
        wdata_o = 8'h00;
    end
    // One framed access; pulses seen after release are gathered
    task automatic xfer(input logic rd, input logic [3:0] sel_n,
        input logic [1:0] chn, input logic stat_n, input logic [2:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic oe,
        output logic [3:0] seen);
        seen = 4'h0;
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        chan_o = chn;
        status_select_n_o = stat_n;
        read_write_o = rd;
        if (style16_i)
        begin
            sel_n_o = sel_n;
            read_strobe_n_o = !rd;
            write_strobe_n_o = rd;
        end
        else
            shared_select_n_o = sel_n[0];
        repeat (3) @(negedge mclk_i);
        q = rdata_i;
        oe = rdata_oe_i;
        sel_n_o = 4'hf;
        shared_select_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        status_select_n_o = 1'b1;
        wdata_o = ~wdata_o;
        repeat (5)
        begin
            @(negedge mclk_i);
            seen = seen | push_i | pop_i;
        end
    endtask : xfer
endmodule : uart_host_model
`default_nettype wire

/* File: verification/test_quad_uart_host_channel_select.sv */
// Self-checking bench for the quad UART host port
`default_nettype none
module test_quad_uart_host_channel_select;
    import uart_host_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic style = 1'b1;
    logic rpin = 1'b0;
    logic strap = 1'b1;
    logic istyle = 1'b0;
    logic [3:0] txr = 4'ha;
    logic [3:0] rxr = 4'h5;
    logic [3:0] irqr = 4'h6;
    logic [3:0] sel_n, push, pop, div4, resume, irq, irq_oe;
    logic ss_n, rw, rs_n, ws_n, st_n, oe, creset, wasoe;
    logic [1:0] chn;
    logic [2:0] addr;
    logic [7:0] wd, rdata, txd, q;
    logic [3:0] seen;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 mclk_i = ~mclk_i;
    uart_host_port i_dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .bus_style_select_i(style), .reset_pin_i(rpin),
        .prescale_pin_select_i(strap), .irq_style_pin_i(istyle),
        .chan_a_select_n_i(sel_n[0]), .chan_b_select_n_i(sel_n[1]),
        .chan_c_select_n_i(sel_n[2]), .chan_d_select_n_i(sel_n[3]),
        .shared_select_n_i(ss_n), .read_write_i(rw),
        .chan_addr_hi_i(chn[1]), .chan_addr_lo_i(chn[0]),
        .read_strobe_n_i(rs_n), .write_strobe_n_i(ws_n),
        .status_select_n_i(st_n), .addr_i(addr), .data_i(wd),
        .tx_space_ready_n_i(txr), .rx_data_ready_n_i(rxr), .irq_req_i(irqr),
        .rx_data_i(32'h4d3c5b2a), .isr_i(32'h0), .lsr_i(32'h0),
        .msr_i(32'h0), .data_o(rdata), .data_oe_o(oe),
        .chan_reset_o(creset), .tx_data_o(txd), .tx_push_o(push),
        .rx_pop_o(pop), .div4_o(div4), .resume_any_o(resume),
        .tick16_o(), .irq_o(irq), .irq_oe_o(irq_oe));
    uart_host_model h (.mclk_i(mclk_i), .style16_i(style),
        .rdata_i(rdata), .rdata_oe_i(oe), .push_i(push), .pop_i(pop),
        .sel_n_o(sel_n), .shared_select_n_o(ss_n), .read_write_o(rw),
        .chan_o(chn), .read_strobe_n_o(rs_n), .write_strobe_n_o(ws_n),
        .status_select_n_o(st_n), .addr_o(addr), .wdata_o(wd));
    task automatic check(input string what, input logic [31:0] seen_v,
        input logic [31:0] exp);
        samples_checked++;
        if (seen_v !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : check
    task automatic complete_run();
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            complete_run();
        end
    end
    // ********************
    // Main sequence
    // ********************
    initial
    begin
        repeat (16) @(posedge mclk_i);
        @(negedge mclk_i) rst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        check("div4", div4, 4'h0);
        for (int i = 0; i < 4; i++)
        begin
            h.xfer(1'b0, ~(4'h1 << i), 2'h3, 1'b1, REG_HOLD, 8'(8'h30 + i),
                q, wasoe, seen);
            check("push", seen, 4'h1 << i);
            check("txd", txd, 8'(8'h30 + i));
        end
        h.xfer(1'b0, 4'h0, 2'h0, 1'b1, REG_HOLD, 8'h77, q, wasoe, seen);
        check("bcast", seen, 4'hf);
        check("bcast_oe", wasoe, 1'b0);
        h.xfer(1'b0, 4'hc, 2'h0, 1'b1, REG_HOLD, 8'h11, q, wasoe, seen);
        check("odd_sel", seen, 4'h0);
        h.xfer(1'b1, 4'hd, 2'h0, 1'b1, REG_HOLD, 8'h00, q, wasoe, seen);
        check("rd_b", q, 8'h5b);
        check("rd_b_oe", wasoe, 1'b1);
        check("rd_b_pop", seen, 4'h2);
        h.xfer(1'b1, 4'h0, 2'h0, 1'b1, REG_HOLD, 8'h00, q, wasoe, seen);
        check("rd_all_oe", {wasoe, seen}, 5'h0);
        h.xfer(1'b1, 4'hf, 2'h0, 1'b0, REG_HOLD, 8'h00, q, wasoe, seen);
        check("status", q, 8'h5a);
        h.xfer(1'b0, 4'he, 2'h0, 1'b1, REG_MCR, 8'ha8, q, wasoe, seen);
        check("div4_mcr", div4, 4'h1);
        check("resume", resume, 4'h1);
        check("irq_oe_sw", irq_oe, 4'h1);
        check("irq", irq, 4'h6);
        @(negedge mclk_i) istyle = 1'b1;
        repeat (3) @(negedge mclk_i);
        check("irq_oe_cont", irq_oe, 4'hf);
        rpin = 1'b1;
        repeat (2) @(negedge mclk_i);
        rpin = 1'b0;
        repeat (4) @(negedge mclk_i);
        check("pin_clear", {div4, resume}, 8'h00);
        style = 1'b0;
        rpin = 1'b1;
        repeat (2) @(negedge mclk_i);
        for (int i = 0; i < 4; i++)
        begin
            h.xfer(1'b0, 4'he, 2'(i), 1'b1, REG_HOLD, 8'h40, q, wasoe, seen);
            check("push68", seen, 4'h1 << i);
        end
        h.xfer(1'b0, 4'hf, 2'h1, 1'b1, REG_HOLD, 8'h41, q, wasoe, seen);
        check("desel68", seen, 4'h0);
        h.xfer(1'b1, 4'he, 2'h2, 1'b1, REG_HOLD, 8'h00, q, wasoe, seen);
        check("rd68", {wasoe, q}, 9'h13c);
        h.xfer(1'b0, 4'he, 2'h0, 1'b1, REG_MCR, 8'h80, q, wasoe, seen);
        rpin = 1'b0;
        repeat (2) @(negedge mclk_i);
        rpin = 1'b1;
        repeat (4) @(negedge mclk_i);
        check("pin68", div4, 4'h0);
        strap = 1'b0;
        rst_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        check("strap_div4", div4, 4'hf);
        complete_run();
    end
endmodule : test_quad_uart_host_channel_select
`default_nettype wire
